// ===== verilog/vout_reference_trim_slew.sv
// output reference trim and margin control with a stepped slew engine, behind a management link
`timescale 1ns/1ps
module vout_reference_trim_slew import trim_pkg::*; #(
    parameter logic [6:0] DEV_ADDR           = 7'h36,
    parameter int         START_DELAY_CYCLES = START_DELAY_CYC
) (
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    output logic        sda_o,
    output logic        sda_oe,
    output logic [15:0] ref_code,
    output logic        ref_moving,
    output logic [2:0]  supply_lockout_level,
    output logic [1:0]  slew_interval_select
);
    typedef enum logic [2:0] {
        L_IDLE = 3'b000,
        L_ADDR = 3'b001,
        L_CMD  = 3'b010,
        L_DATA = 3'b011,
        L_TX   = 3'b100,
        L_SKIP = 3'b101
    } link_e;

    typedef enum logic [1:0] {
        E_IDLE  = 2'b00,
        E_DELAY = 2'b01,
        E_STEP  = 2'b10
    } eng_e;

    logic             scl_rise;
    logic             scl_fall;
    logic             start_cond;
    logic             stop_cond;
    logic             sda_s;

    link_e            link_reg;
    logic [3:0]       bit_cnt_reg;
    logic [7:0]       shift_reg;
    logic [7:0]       tx_reg;
    logic             ack_slot_reg;
    logic [7:0]       cmd_reg;
    logic             wr_pulse_reg;
    logic [7:0]       wr_data_reg;
    logic [7:0]       read_mux;

    logic [7:0]       op_reg;
    logic [7:0]       soft_reg;
    logic [4:0]       fine_reg;
    logic [7:0]       margin_reg;
    logic [2:0]       uv_reg;
    logic             retarget_reg;
    margin_e          margin_sel;
    trim_cfg_s        cfg;
    logic [15:0]      target;

    eng_e             eng_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] interval;
    logic [15:0]      ref_reg;
    logic             moving_reg;

    line_sampler u_pins (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .scl_rise   (scl_rise),
        .scl_fall   (scl_fall),
        .start_cond (start_cond),
        .stop_cond  (stop_cond),
        .sda_s      (sda_s)
    );

    // byte readback of the stored settings; unknown commands read as zero
    always_comb begin
        unique case (cmd_reg)
            CMD_OPERATION:  read_mux = op_reg;
            CMD_SOFT_START: read_mux = soft_reg;
            CMD_FINE_TRIM:  read_mux = {3'h0, fine_reg};
            CMD_MARGIN:     read_mux = margin_reg;
            CMD_UV_THRESH:  read_mux = {5'h00, uv_reg};
            default:        read_mux = 8'h00;
        endcase
    end

    // link engine: bits are taken on clock rise, our data and acks change on clock fall
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            link_reg     <= L_IDLE;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            ack_slot_reg <= 1'b0;
            cmd_reg      <= 8'h00;
            wr_pulse_reg <= 1'b0;
            wr_data_reg  <= 8'h00;
            sda_oe       <= 1'b0;
        end else begin
            wr_pulse_reg <= 1'b0;
            if (start_cond) begin
                // a repeated start also lands here, so a read may follow a command byte
                link_reg     <= L_ADDR;
                bit_cnt_reg  <= 4'h0;
                ack_slot_reg <= 1'b0;
                sda_oe       <= 1'b0;
            end else if (stop_cond) begin
                link_reg     <= L_IDLE;
                bit_cnt_reg  <= 4'h0;
                ack_slot_reg <= 1'b0;
                sda_oe       <= 1'b0;
            end else if (scl_rise && !ack_slot_reg && link_reg != L_IDLE && link_reg != L_SKIP) begin
                shift_reg   <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && ack_slot_reg) begin
                // end of our ack slot: release, or put out the first read bit
                ack_slot_reg <= 1'b0;
                bit_cnt_reg  <= 4'h0;
                if (link_reg == L_TX) begin
                    sda_oe <= ~tx_reg[7];
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end else begin
                    sda_oe <= 1'b0;
                end
            end else if (scl_fall && link_reg == L_TX && bit_cnt_reg < 4'(BYTE_BITS)) begin
                sda_oe <= ~tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end else if (scl_fall && bit_cnt_reg == 4'(BYTE_BITS)) begin
                unique case (link_reg)
                    L_ADDR: begin
                        if (shift_reg[7:1] == DEV_ADDR) begin
                            ack_slot_reg <= 1'b1;
                            sda_oe       <= 1'b1;
                            tx_reg       <= read_mux;
                            link_reg     <= shift_reg[0] ? L_TX : L_CMD;
                        end else begin
                            link_reg <= L_SKIP;
                        end
                    end
                    L_CMD: begin
                        cmd_reg      <= shift_reg;
                        ack_slot_reg <= 1'b1;
                        sda_oe       <= 1'b1;
                        link_reg     <= L_DATA;
                    end
                    L_DATA: begin
                        // one data byte per transfer; further bytes are not acknowledged
                        wr_pulse_reg <= 1'b1;
                        wr_data_reg  <= shift_reg;
                        ack_slot_reg <= 1'b1;
                        sda_oe       <= 1'b1;
                        link_reg     <= L_SKIP;
                    end
                    L_TX: begin
                        sda_oe   <= 1'b0;
                        link_reg <= L_SKIP;
                    end
                    L_IDLE, L_SKIP: begin
                        link_reg <= link_reg;
                    end
                    default: begin
                        link_reg <= L_IDLE;
                    end
                endcase
            end
        end
    end

    // open-drain data line only ever pulls low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // configuration bytes written over the link
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            op_reg     <= OP_RESET;
            soft_reg   <= SOFT_RESET;
            fine_reg   <= FINE_RESET;
            margin_reg <= MARGIN_RESET;
            uv_reg     <= UV_RESET;
        end else if (wr_pulse_reg) begin
            unique case (cmd_reg)
                CMD_OPERATION:  op_reg <= wr_data_reg;
                CMD_SOFT_START: soft_reg <= wr_data_reg;
                CMD_FINE_TRIM:  fine_reg <= wr_data_reg[4:0];
                CMD_MARGIN:     margin_reg <= wr_data_reg;
                CMD_UV_THRESH: begin
                    // upper bits dropped; the unsupported code leaves the old level in place
                    if (wr_data_reg[2:0] != UV_UNSUPPORTED) begin
                        uv_reg <= wr_data_reg[2:0];
                    end
                end
                default: begin
                    uv_reg <= uv_reg;
                end
            endcase
        end
    end

    // margin selection from the operation byte; the undefined code counts as off
    always_comb begin
        unique case (op_reg[OP_MARGIN_LSB +: 2])
            2'b01:   margin_sel = MARGIN_LOW;
            2'b10:   margin_sel = MARGIN_HIGH;
            default: margin_sel = MARGIN_OFF;
        endcase
        cfg.fine_trim_code = fine_reg;
        cfg.raise_level    = margin_reg[RAISE_LSB +: 4];
        cfg.lower_level    = margin_reg[3:0];
        cfg.margin_sel     = margin_sel;
    end

    // writes that change the target restart the start delay
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            retarget_reg <= 1'b0;
        end else begin
            retarget_reg <= wr_pulse_reg &&
                            (cmd_reg == CMD_FINE_TRIM ||
                             cmd_reg == CMD_OPERATION ||
                             (cmd_reg == CMD_MARGIN && margin_sel != MARGIN_OFF));
        end
    end

    trim_target_calc u_calc (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cfg     (cfg),
        .target  (target)
    );

    // step interval: base interval doubled per code of the slew field
    assign interval = STEP_BASE_CYC << soft_reg[SLEW_LSB +: 2];

    // slew engine; the delay hides the one-cycle latency of the target calculation
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            eng_reg    <= E_IDLE;
            cnt_reg    <= '0;
            ref_reg    <= NOMINAL_CODE;
            moving_reg <= 1'b0;
        end else if (retarget_reg) begin
            // a new target keeps the present code and waits again
            eng_reg    <= E_DELAY;
            cnt_reg    <= '0;
            moving_reg <= 1'b1;
        end else begin
            unique case (eng_reg)
                E_IDLE: begin
                    cnt_reg <= '0;
                end
                E_DELAY: begin
                    if (cnt_reg == CNT_W'(START_DELAY_CYCLES - 1)) begin
                        cnt_reg <= '0;
                        eng_reg <= E_STEP;
                        if (ref_reg < target) begin
                            ref_reg <= ref_reg + 16'h0001;
                        end else if (ref_reg > target) begin
                            ref_reg <= ref_reg - 16'h0001;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                E_STEP: begin
                    if (cnt_reg == interval - 1'b1) begin
                        cnt_reg <= '0;
                        if (ref_reg < target) begin
                            ref_reg <= ref_reg + 16'h0001;
                        end else if (ref_reg > target) begin
                            ref_reg <= ref_reg - 16'h0001;
                        end else begin
                            eng_reg    <= E_IDLE;
                            moving_reg <= 1'b0;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    eng_reg <= E_IDLE;
                end
            endcase
        end
    end

    assign ref_code             = ref_reg;
    assign ref_moving           = moving_reg;
    assign supply_lockout_level = uv_reg;
    assign slew_interval_select = soft_reg[SLEW_LSB +: 2];
endmodule

// ===== verilog/trim_pkg.sv
// shared constants, types and tables for the output reference trim block
package trim_pkg;
    // timebase
    localparam int CLK_MHZ        = 200;
    localparam int START_DELAY_US = 50;
    localparam int STEP_BASE_US   = 4;
    localparam int START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
    localparam logic [15:0] STEP_BASE_CYC = 16'(STEP_BASE_US * CLK_MHZ);
    localparam int CNT_W = 16;

    // command codes on the management link
    localparam logic [7:0] CMD_OPERATION  = 8'h01;
    localparam logic [7:0] CMD_SOFT_START = 8'hd2;
    localparam logic [7:0] CMD_FINE_TRIM  = 8'hd4;
    localparam logic [7:0] CMD_MARGIN     = 8'hd5;
    localparam logic [7:0] CMD_UV_THRESH  = 8'hd6;

    // reset values, and the unsupported lockout code
    localparam logic [7:0] OP_RESET        = 8'h80;
    localparam logic [7:0] SOFT_RESET      = 8'h00;
    localparam logic [4:0] FINE_RESET      = 5'h10;
    localparam logic [7:0] MARGIN_RESET    = 8'h55;
    localparam logic [2:0] UV_RESET        = 3'h5;
    localparam logic [2:0] UV_UNSUPPORTED  = 3'h4;

    // field positions
    localparam int OP_MARGIN_LSB = 4;
    localparam int SLEW_LSB      = 2;
    localparam int RAISE_LSB     = 4;
    localparam int BYTE_BITS     = 8;

    // reference code is in units of 0.01 % of the nominal reference
    localparam logic [15:0] NOMINAL_CODE = 16'h2710;
    localparam logic [14:0] FACTOR_ONE   = 15'h2710;
    localparam logic [14:0] FINE_STEP    = 15'h004b;
    localparam logic [14:0] FINE_MAX     = 15'h0384;
    localparam logic [14:0] MARGIN_UNIT  = 15'h000a;
    localparam logic [29:0] PROD_DIV     = 30'h0000_2710;
    localparam logic [3:0]  LEVEL_TOP    = 4'hc;

    // margin magnitudes in 0.1 % units, index 12 stands for every 11xx code
    localparam logic [6:0] RAISE_TBL [13] = '{7'h00, 7'h09, 7'h12, 7'h1c, 7'h25, 7'h2f, 7'h39,
                                              7'h43, 7'h4d, 7'h58, 7'h63, 7'h6d, 7'h78};
    localparam logic [6:0] LOWER_TBL [13] = '{7'h00, 7'h0b, 7'h15, 7'h20, 7'h2a, 7'h34, 7'h3e,
                                              7'h47, 7'h51, 7'h5a, 7'h63, 7'h6b, 7'h74};

    typedef enum logic [1:0] {
        MARGIN_OFF  = 2'b00,
        MARGIN_LOW  = 2'b01,
        MARGIN_HIGH = 2'b10
    } margin_e;

    typedef struct packed {
        logic [4:0] fine_trim_code;
        logic [3:0] raise_level;
        logic [3:0] lower_level;
        margin_e    margin_sel;
    } trim_cfg_s;
endpackage

// ===== verilog/line_sampler.sv
// two-flop synchronisers and edge / bus-condition detection for the serial link pins
`timescale 1ns/1ps
module line_sampler import trim_pkg::*; (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_cond,
    output logic      stop_cond,
    output logic      sda_s
);
    logic [2:0] scl_pipe;
    logic [2:0] sda_pipe;

    // stage 0 feeds only stage 1; stages 1 and 2 feed the detectors
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_pipe <= 3'h7;
            sda_pipe <= 3'h7;
        end else begin
            scl_pipe <= {scl_pipe[1:0], scl_i};
            sda_pipe <= {sda_pipe[1:0], sda_i};
        end
    end

    // start and stop need clock high in both compared samples
    always_comb begin
        sda_s      = sda_pipe[1];
        scl_rise   = scl_pipe[1] & ~scl_pipe[2];
        scl_fall   = ~scl_pipe[1] & scl_pipe[2];
        start_cond = scl_pipe[1] & scl_pipe[2] & sda_pipe[2] & ~sda_pipe[1];
        stop_cond  = scl_pipe[1] & scl_pipe[2] & ~sda_pipe[2] & sda_pipe[1];
    end
endmodule

// ===== verilog/trim_target_calc.sv
// target reference code from fine trim and margin settings, registered
`timescale 1ns/1ps
module trim_target_calc import trim_pkg::*; (
    input  wire logic      clk_sys,
    input  wire logic      rst,
    input  wire trim_cfg_s cfg,
    output logic [15:0]    target
);
    logic [14:0] fine_fac;
    logic [14:0] marg_fac;
    logic [3:0]  raise_idx;
    logic [3:0]  lower_idx;
    logic [29:0] prod;

    // fine factor: 0.75 % steps, saturating at +-9 %
    always_comb begin
        if (cfg.fine_trim_code[4:2] == 3'b111) begin
            fine_fac = FACTOR_ONE + FINE_MAX;
        end else if (cfg.fine_trim_code[4:2] == 3'b000) begin
            fine_fac = FACTOR_ONE - FINE_MAX;
        end else if (cfg.fine_trim_code[4]) begin
            fine_fac = FACTOR_ONE + 15'(cfg.fine_trim_code[3:0] * FINE_STEP);
        end else begin
            fine_fac = FACTOR_ONE - 15'((4'hf - cfg.fine_trim_code[3:0]) * FINE_STEP);
        end
    end

    // margin factor from the field that the operation setting selects
    always_comb begin
        raise_idx = (cfg.raise_level[3:2] == 2'b11) ? LEVEL_TOP : cfg.raise_level;
        lower_idx = (cfg.lower_level[3:2] == 2'b11) ? LEVEL_TOP : cfg.lower_level;
        unique case (cfg.margin_sel)
            MARGIN_HIGH: marg_fac = FACTOR_ONE + 15'(RAISE_TBL[raise_idx] * MARGIN_UNIT);
            MARGIN_LOW:  marg_fac = FACTOR_ONE - 15'(LOWER_TBL[lower_idx] * MARGIN_UNIT);
            default:     marg_fac = FACTOR_ONE;
        endcase
    end

    // both settings act together as a product
    assign prod = 30'(fine_fac) * 30'(marg_fac);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            target <= NOMINAL_CODE;
        end else begin
            target <= 16'(prod / PROD_DIV);
        end
    end
endmodule

// ===== tb/link_host.sv
// behavioural management-link host driving the clock pin and the open-drain data pin
`timescale 1ns/1ps
module link_host #(
    parameter int         HALF = 16,
    parameter logic [6:0] ADDR = 7'h36
) (
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output logic      scl_o,
    output logic      sda_low
);
    // idle bus: clock stands high, data released to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_q();
        repeat (HALF) @(negedge clk_sys);
    endtask

    // data moves two cycles clear of the clock fall, so it is never seen as a start or stop;
    // the low phase still totals one half period so the link clock keeps its nominal rate
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(negedge clk_sys);
        sda_low = ~b;
        repeat (HALF - 2) @(negedge clk_sys);
        scl_o = 1'b1;
        wait_q();
        r = sda_line;
        scl_o = 1'b0;
    endtask

    task automatic start();
        sda_low = 1'b0;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        sda_low = 1'b1;
        wait_q();
        scl_o = 1'b0;
    endtask

    task automatic stop();
        repeat (2) @(negedge clk_sys);
        sda_low = 1'b1;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        sda_low = 1'b0;
        wait_q();
    endtask

    // eight bits msb first, then a released ninth bit; host never acks read data
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // margining is switched only through the operation command byte
    task automatic write_reg(input logic [7:0] c, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2;
        start();
        xfer({ADDR, 1'b0}, q, a0);
        xfer(c, q, a1);
        xfer(d, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    task automatic read_reg(input logic [7:0] c, output logic [7:0] q);
        logic a;
        start();
        xfer({ADDR, 1'b0}, q, a);
        xfer(c, q, a);
        start();
        xfer({ADDR, 1'b1}, q, a);
        xfer(8'hff, q, a);
        stop();
    endtask
endmodule

// ===== tb/vout_reference_trim_slew_checker.sv
// concurrent checks on the reference trim block ports
`timescale 1ns/1ps
module vout_reference_trim_slew_checker import trim_pkg::*; #(
    parameter int START_DELAY_CYCLES = 20
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic [15:0] ref_code,
    input wire logic        ref_moving,
    input wire logic [2:0]  supply_lockout_level,
    input wire logic [1:0]  slew_interval_select
);
    localparam int BASE    = int'(STEP_BASE_CYC);
    localparam int MIN_GAP = ((START_DELAY_CYCLES < BASE) ? START_DELAY_CYCLES : BASE) - 1;
    logic [15:0] gap_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // cycles since the reference last moved; saturates so long idles do not wrap
    always_ff @(posedge clk_sys) begin
        if (rst || $changed(ref_code)) begin
            gap_reg <= 16'h0000;
        end else if (gap_reg != 16'hffff) begin
            gap_reg <= gap_reg + 16'h0001;
        end
    end

    property p_step_size;
        $changed(ref_code) |-> ref_code == $past(ref_code) + 16'h0001 || ref_code == $past(ref_code) - 16'h0001;
    endproperty
    a_step_size: assert property (p_step_size) else $error("reference moved by more than one code");
    property p_step_gap;
        $changed(ref_code) |-> gap_reg >= MIN_GAP;
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("reference steps too close");
    property p_step_moving;
        $changed(ref_code) |-> $past(ref_moving);
    endproperty
    a_step_moving: assert property (p_step_moving) else $error("reference stepped while idle");
    property p_settle_hold;
        $fell(ref_moving) |-> gap_reg >= MIN_GAP ##1 $stable(ref_code) [*8];
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("engine idled too early");
    property p_retarget_ack;
        $rose(ref_moving) |-> sda_oe;
    endproperty
    a_retarget_ack: assert property (p_retarget_ack) else $error("move started without a write");
    property p_lockout_write;
        $changed(supply_lockout_level) |-> sda_oe && supply_lockout_level != UV_UNSUPPORTED;
    endproperty
    a_lockout_write: assert property (p_lockout_write) else $error("bad lockout update");
    property p_slew_write;
        $changed(slew_interval_select) |-> sda_oe;
    endproperty
    a_slew_write: assert property (p_slew_write) else $error("slew select moved without a write");
    property p_data_low_clock;
        $changed(sda_oe) |-> !scl_i && !$past(scl_i);
    endproperty
    a_data_low_clock: assert property (p_data_low_clock) else $error("data drive moved with clock high");
    property p_ref_range;
        ref_code >= 16'h1f6c && ref_code <= 16'h2fb0;
    endproperty
    a_ref_range: assert property (p_ref_range) else $error("reference outside combined range");
    property p_drive_low;
        sda_oe |-> !sda_o;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("data pin driven high");
endmodule

bind vout_reference_trim_slew vout_reference_trim_slew_checker #(
    .START_DELAY_CYCLES(START_DELAY_CYCLES)
) u_checker (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .scl_i                (scl_i),
    .sda_i                (sda_i),
    .sda_o                (sda_o),
    .sda_oe               (sda_oe),
    .ref_code             (ref_code),
    .ref_moving           (ref_moving),
    .supply_lockout_level (supply_lockout_level),
    .slew_interval_select (slew_interval_select)
);

// ===== tb/vout_reference_trim_slew_test.sv
// self-checking bench for the reference trim block, driven through a behavioural link host
`timescale 1ns/1ps
module vout_reference_trim_slew_test import trim_pkg::*; ;
    localparam int         DLY  = 200;
    localparam int         Q    = 16;
    localparam logic [6:0] ADDR = 7'h36; // arbitrary bus address
    logic        clk_sys, rst, scl_i, sda_line, sda_o, sda_oe, sda_low, ref_moving, ok;
    logic [15:0] ref_code;
    logic [2:0]  lock, exp_lock;
    logic [1:0]  slew;
    logic [7:0]  rd, rnd;
    int          mismatches, num_checks;
    logic [7:0]  cmds [5] = '{CMD_SOFT_START, CMD_FINE_TRIM, CMD_MARGIN, CMD_UV_THRESH, 8'h9c};
    logic [7:0]  exps [5] = '{SOFT_RESET, {3'h0, FINE_RESET}, MARGIN_RESET, {5'h0, UV_RESET}, 8'h00};

    // pulled-up data wire: low when either side pulls
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

    vout_reference_trim_slew #(.DEV_ADDR(ADDR), .START_DELAY_CYCLES(DLY)) DUT (
        .clk_sys(clk_sys), .rst(rst), .scl_i(scl_i), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .ref_code(ref_code), .ref_moving(ref_moving), .supply_lockout_level(lock), .slew_interval_select(slew));
    link_host #(.HALF(Q), .ADDR(ADDR)) host (
        .clk_sys(clk_sys), .sda_line(sda_line), .scl_o(scl_i), .sda_low(sda_low));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        host.write_reg(c, d, ok);
        check("write ack", {15'h0, ok}, 16'h0001);
    endtask

    // waits for the reference to move, or for the engine to idle when idle is set
    task automatic wait_ev(input logic idle, input int bound, output int n);
        logic [15:0] r0;
        r0 = ref_code;
        n = 0;
        while (idle ? ref_moving !== 1'b0 : ref_code === r0) begin
            @(negedge clk_sys);
            n++;
            if (n > bound) begin
                check("wait bound", 16'h0, 16'h1);
                finish_test();
            end
        end
    endtask

    // retargeting write, then start delay, direction of the first step and spacing to the next;
    // the delay window allows for the frame tail after the data byte is taken
    task automatic seg(input logic [7:0] c, input logic [7:0] d, input logic up, input int iv);
        logic [15:0] r0;
        int          n;
        wr(c, d);
        r0 = ref_code;
        wait_ev(1'b0, DLY, n);
        check("start delay", 16'(n >= DLY - 90 && n <= DLY - 70), 16'h1);
        check("first step", ref_code, up ? r0 + 16'h0001 : r0 - 16'h0001);
        wait_ev(1'b0, iv + 10, n);
        check("step interval", 16'(n), 16'(iv));
    endtask

    task automatic settle(input logic [15:0] exp);
        int n;
        wait_ev(1'b1, 30000, n);
        check("settled reference", ref_code, exp);
    endtask

    initial begin
        rst = 1'b1;
        mismatches = 0;
        num_checks = 0;
        void'($urandom(93));
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("reset reference", ref_code, NOMINAL_CODE);
        check("reset lockout", {13'h0, lock}, {13'h0, UV_RESET});
        check("reset slew", {14'h0, slew}, 16'h0000);
        foreach (cmds[i]) begin
            host.read_reg(cmds[i], rd);
            check("read back", {8'h0, rd}, {8'h0, exps[i]});
        end
        // every lockout code, upper bits random; the unsupported code leaves the old value
        exp_lock = UV_RESET;
        for (int i = 7; i >= 0; i--) begin
            exp_lock = (i == 4) ? exp_lock : 3'(i);
            wr(CMD_UV_THRESH, {5'($urandom), 3'(i)});
            check("lockout level", {13'h0, lock}, {13'h0, exp_lock});
        end
        // margining from defaults, retargets while enabled, then fine trim on top
        rnd = 8'($urandom_range(15, 1));
        seg(CMD_OPERATION, 8'ha0, 1'b1, 800);
        seg(CMD_MARGIN, {4'h0, rnd[3:0]}, 1'b0, 800);
        seg(CMD_OPERATION, 8'h90, 1'b0, 800);
        seg(CMD_MARGIN, {2'b11, rnd[1:0], rnd[3:0]}, 1'b0, 800);
        seg(CMD_OPERATION, 8'ha0, 1'b1, 800);
        seg(CMD_FINE_TRIM, {6'h00, rnd[1:0]}, 1'b1, 800);
        seg(CMD_OPERATION, 8'h80, 1'b0, 800);
        // longer intervals, alternating trim direction
        for (int s = 1; s < 4; s++) begin
            rnd = 8'($urandom);
            wr(CMD_SOFT_START, {rnd[7:4], 2'(s), rnd[1:0]});
            check("slew select", {14'h0, slew}, 16'(s));
            rnd = (s % 2) ? 8'($urandom_range(31, 17)) : 8'($urandom_range(14, 0));
            seg(CMD_FINE_TRIM, rnd, 1'(s % 2), 800 << s);
        end
        // back to nominal, then zero margin codes must leave it exactly there
        wr(CMD_SOFT_START, 8'h00);
        wr(CMD_FINE_TRIM, {3'h0, FINE_RESET});
        settle(NOMINAL_CODE);
        wr(CMD_MARGIN, 8'h00);
        check("no retarget when off", {15'h0, ref_moving}, 16'h0000);
        wr(CMD_OPERATION, 8'ha0);
        settle(NOMINAL_CODE);
        wr(CMD_OPERATION, 8'h90);
        settle(NOMINAL_CODE);
        finish_test();
    end
endmodule
